// ===== src/tsf_pkg.sv
// Purpose: constants for the temperature sample queue
// Assumes: byte-wide register port driven by the serial slave engine
// Notes:   offsets are byte register addresses
package tsf_pkg;
   localparam int unsigned SAMPLE_W    = 16;
   localparam int unsigned QUEUE_DEPTH = 32;
   localparam int unsigned PTR_W       = 5;
   localparam int unsigned CNT_W       = 6;
   localparam int unsigned LOST_W      = 5;
   localparam int unsigned WM_W        = 5;

   localparam logic [7:0] OFS_STATUS       = 8'h00;
   localparam logic [7:0] OFS_WRITE_INDEX  = 8'h04;
   localparam logic [7:0] OFS_READ_INDEX   = 8'h05;
   localparam logic [7:0] OFS_LOST_COUNT   = 8'h06;
   localparam logic [7:0] OFS_WAIT_COUNT   = 8'h07;
   localparam logic [7:0] OFS_DATA_PORT    = 8'h08;
   localparam logic [7:0] OFS_WATERMARK    = 8'h09;
   localparam logic [7:0] OFS_BEHAVIOUR    = 8'h0A;

   localparam int unsigned BIT_ROLLOVER    = 1;
   localparam int unsigned BIT_AFULL_TYPE  = 2;
   localparam int unsigned BIT_STAT_CLR    = 3;
   localparam int unsigned BIT_FLUSH       = 4;

   localparam logic [1:0]  PIN_FUNC_INTR   = 2'h3;
   localparam logic [LOST_W-1:0] LOST_MAX  = 5'h1F;
   localparam logic [WM_W-1:0]   WM_RESET  = 5'h00;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
endpackage : tsf_pkg

// ===== src/tsf_queue_if.sv
// Purpose: carrier between the register front and the sample queue
// Assumes: single clock domain
// Notes:   push and pop use valid/ready
`timescale 1ns/10ps
interface tsf_queue_if #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned PTR_W = 5,
   parameter int unsigned CNT_W = 6
);
   logic             push_valid;
   logic             push_ready;
   logic [WIDTH-1:0] push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [WIDTH-1:0] pop_data;
   logic [PTR_W-1:0] wr_index;
   logic [PTR_W-1:0] rd_index;
   logic [CNT_W-1:0] count;
   logic             full;
   logic             rd_load;
   logic [PTR_W-1:0] rd_load_val;
   logic             flush;
   logic             rollover;

   modport front (output push_valid, push_data, pop_ready, rd_load, rd_load_val, flush,
                  rollover, input push_ready, pop_valid, pop_data, wr_index, rd_index,
                  count, full);
   modport queue (input push_valid, push_data, pop_ready, rd_load, rd_load_val, flush,
                  rollover, output push_ready, pop_valid, pop_data, wr_index, rd_index,
                  count, full);
endinterface : tsf_queue_if

// ===== src/tsf_queue.sv
// Purpose: sample storage with wrapping pointers and optional overwrite
// Assumes: depth is a power of two matching the pointer width
// Notes:   pop data is read combinationally at the read index
`timescale 1ns/10ps
module tsf_queue #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned PTR_W = 5,
   parameter int unsigned CNT_W = 6
) (
   input  wire logic clk_in,
   input  wire logic rst_n,
   tsf_queue_if.queue q
);
   initial begin
      if ((1 << PTR_W) != DEPTH || (1 << (CNT_W - 1)) != DEPTH)
         $error("tsf_queue: depth must equal 2**PTR_W and 2**(CNT_W-1)");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q;
   logic [PTR_W-1:0] rd_q;
   logic [CNT_W-1:0] cnt_q;

   wire              full_w    = (cnt_q == CNT_W'(DEPTH));
   wire              empty_w   = (cnt_q == '0);
   wire              push_fire = q.push_valid && q.push_ready;
   wire              pop_fire  = q.pop_valid && q.pop_ready;
   wire              overwrite = push_fire && full_w && !pop_fire;
   wire              rd_step   = pop_fire || overwrite;
   wire [PTR_W-1:0]  load_diff = wr_q - q.rd_load_val;

   assign q.push_ready = !full_w || q.rollover;
   assign q.pop_valid  = !empty_w;
   assign q.pop_data   = mem_q[rd_q];
   assign q.wr_index   = wr_q;
   assign q.rd_index   = rd_q;
   assign q.count      = cnt_q;
   assign q.full       = full_w;

   always_ff @(posedge clk_in) begin
      if (push_fire) begin
         mem_q[wr_q] <= q.push_data;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (q.flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (q.rd_load) begin
         rd_q  <= q.rd_load_val;
         cnt_q <= {1'b0, load_diff};
      end else begin
         if (push_fire) wr_q <= wr_q + 1'b1;
         if (rd_step) rd_q <= rd_q + 1'b1;
         if (push_fire && !full_w && !pop_fire) cnt_q <= cnt_q + 1'b1;
         else if (pop_fire && !push_fire) cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule : tsf_queue

// ===== src/tsf_sample_fifo.sv
// Purpose: register front of the temperature sample queue
// Assumes: register strobes come from the serial slave engine on clk_in
// Notes:   status and pin setup bits of other blocks arrive as plain inputs
`timescale 1ns/10ps
// What this block does
// - six-bit readable count of waiting samples
// - count up on push, down on pop
// - byte data port; two-byte burst pops one
// - each entry holds one 16-bit sample
// - high byte first, low byte second
// - pointers readable; difference equals waiting count except when full
// - almost full at 32 minus watermark words
// - almost full condition sets status flag
// - pin zero interrupt when flag, enable, mode
// - rollover overwrites oldest when full
// - no rollover discards new sample when full
// - style low: flag resets each sample
// - style high: flag only on new condition
// - lost count saturates, cleared by pop
// - hold address pointer on data port access
// - status read clears flags; option data read
// - flush empties queue and zeroes counters
module tsf_sample_fifo #(
   parameter int unsigned DEPTH = tsf_pkg::QUEUE_DEPTH
) (
   input  wire logic                         clk_in,
   input  wire logic                         resetn_in,
   input  wire logic                         sample_valid_in,
   input  wire logic [tsf_pkg::SAMPLE_W-1:0] sample_in,
   output logic                              sample_ready_out,
   input  wire logic [7:0]                   reg_addr_in,
   input  wire logic                         reg_wr_in,
   input  wire logic [7:0]                   reg_wdata_in,
   input  wire logic                         reg_rd_in,
   output logic [7:0]                        reg_rdata_out,
   output logic                              addr_hold_out,
   input  wire logic                         afull_int_en_in,
   input  wire logic [1:0]                   pin_zero_function_in,
   output logic                              almost_full_flag_out,
   output logic                              temp_ready_flag_out,
   output logic                              interrupt_pin_zero_out
);
   initial begin
      if (DEPTH != tsf_pkg::QUEUE_DEPTH)
         $error("tsf_sample_fifo: depth is fixed by the pointer width");
   end

   logic rst_meta_q;
   logic rst_n_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   tsf_queue_if #(.WIDTH(tsf_pkg::SAMPLE_W), .PTR_W(tsf_pkg::PTR_W),
                  .CNT_W(tsf_pkg::CNT_W)) qif ();

   tsf_queue #(.WIDTH(tsf_pkg::SAMPLE_W), .DEPTH(DEPTH), .PTR_W(tsf_pkg::PTR_W),
               .CNT_W(tsf_pkg::CNT_W)) u_queue (
      .clk_in (clk_in),
      .rst_n  (rst_n_q),
      .q      (qif.queue)
   );

   logic [tsf_pkg::WM_W-1:0]   wm_q;
   logic                       rollover_q;
   logic                       afull_type_q;
   logic                       stat_clr_q;
   logic [tsf_pkg::LOST_W-1:0] lost_q;
   logic                       byte_sel_q;
   logic                       afull_q;
   logic                       cond_q;
   logic                       trdy_q;
   logic                       int_q;
   logic [7:0]                 rdata_q;
   logic                       hold_q;
   logic                       ready_q;

   // register decode
   wire rd_status = reg_rd_in && (reg_addr_in == tsf_pkg::OFS_STATUS);
   wire rd_data   = reg_rd_in && (reg_addr_in == tsf_pkg::OFS_DATA_PORT);
   wire wr_rdidx  = reg_wr_in && (reg_addr_in == tsf_pkg::OFS_READ_INDEX);
   wire wr_wm     = reg_wr_in && (reg_addr_in == tsf_pkg::OFS_WATERMARK);
   wire wr_behav  = reg_wr_in && (reg_addr_in == tsf_pkg::OFS_BEHAVIOUR);
   wire flush_w   = wr_behav && reg_wdata_in[tsf_pkg::BIT_FLUSH];
   wire other_acc = (reg_rd_in || reg_wr_in) && !rd_data;

   wire pop_w     = rd_data && byte_sel_q && qif.pop_valid;
   wire push_w    = sample_valid_in && qif.push_ready;
   wire lost_w    = sample_valid_in && qif.full && !pop_w;

   assign qif.push_valid  = sample_valid_in;
   assign qif.push_data   = sample_in;
   assign qif.pop_ready   = pop_w;
   assign qif.rd_load     = wr_rdidx;
   assign qif.rd_load_val = reg_wdata_in[tsf_pkg::PTR_W-1:0];
   assign qif.flush       = flush_w;
   assign qif.rollover    = rollover_q;

   // count that will hold after this cycle, for the watermark test
   wire [tsf_pkg::CNT_W-1:0] cnt_next =
      (push_w && !qif.full && !pop_w) ? qif.count + 1'b1 :
      (pop_w && !push_w)              ? qif.count - 1'b1 : qif.count;
   wire [tsf_pkg::CNT_W-1:0] thresh =
      tsf_pkg::CNT_W'(DEPTH) - {1'b0, wm_q};
   wire cond_d    = !flush_w && (cnt_next >= thresh) && (cnt_next != '0);
   wire afull_set = afull_type_q ? (cond_d && !cond_q)
                                 : (cond_d && push_w);
   wire flag_clr  = rd_status || (rd_data && stat_clr_q);

   wire [7:0] data_byte = byte_sel_q ? qif.pop_data[7:0]
                                     : qif.pop_data[tsf_pkg::SAMPLE_W-1:8];
   wire [7:0] behav_rd  = {4'h0, stat_clr_q, afull_type_q, rollover_q, 1'b0};
   wire [7:0] rd_mux =
      (reg_addr_in == tsf_pkg::OFS_WRITE_INDEX) ? {3'h0, qif.wr_index} :
      (reg_addr_in == tsf_pkg::OFS_READ_INDEX)  ? {3'h0, qif.rd_index} :
      (reg_addr_in == tsf_pkg::OFS_LOST_COUNT)  ? {3'h0, lost_q} :
      (reg_addr_in == tsf_pkg::OFS_WAIT_COUNT)  ? {2'h0, qif.count} :
      (reg_addr_in == tsf_pkg::OFS_DATA_PORT)   ? (qif.pop_valid ? data_byte
                                                                 : tsf_pkg::BYTE_ZERO) :
      (reg_addr_in == tsf_pkg::OFS_WATERMARK)   ? {3'h0, wm_q} :
      (reg_addr_in == tsf_pkg::OFS_BEHAVIOUR)   ? behav_rd : tsf_pkg::BYTE_ZERO;

   wire int_d = afull_q && afull_int_en_in
                && (pin_zero_function_in == tsf_pkg::PIN_FUNC_INTR);

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wm_q         <= tsf_pkg::WM_RESET;
         rollover_q   <= 1'b0;
         afull_type_q <= 1'b0;
         stat_clr_q   <= 1'b0;
      end else begin
         if (wr_wm) wm_q <= reg_wdata_in[tsf_pkg::WM_W-1:0];
         if (wr_behav) begin
            rollover_q   <= reg_wdata_in[tsf_pkg::BIT_ROLLOVER];
            afull_type_q <= reg_wdata_in[tsf_pkg::BIT_AFULL_TYPE];
            stat_clr_q   <= reg_wdata_in[tsf_pkg::BIT_STAT_CLR];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) lost_q <= '0;
      else if (flush_w || pop_w) lost_q <= '0;
      else if (lost_w && lost_q != tsf_pkg::LOST_MAX) lost_q <= lost_q + 1'b1;
   end

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) byte_sel_q <= 1'b0;
      else if (flush_w || other_acc || wr_rdidx) byte_sel_q <= 1'b0;
      else if (rd_data && qif.pop_valid) byte_sel_q <= !byte_sel_q;
   end

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         afull_q <= 1'b0;
         cond_q  <= 1'b0;
         trdy_q  <= 1'b0;
      end else begin
         cond_q <= cond_d;
         if (afull_set) afull_q <= 1'b1;
         else if (flag_clr) afull_q <= 1'b0;
         if (push_w) trdy_q <= 1'b1;
         else if (flag_clr) trdy_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= tsf_pkg::BYTE_ZERO;
         hold_q  <= 1'b0;
         int_q   <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         if (reg_rd_in) rdata_q <= rd_mux;
         if (reg_rd_in || reg_wr_in) hold_q <= (reg_addr_in == tsf_pkg::OFS_DATA_PORT);
         int_q   <= int_d;
         ready_q <= qif.push_ready;
      end
   end

   assign reg_rdata_out          = rdata_q;
   assign addr_hold_out          = hold_q;
   assign almost_full_flag_out   = afull_q;
   assign temp_ready_flag_out    = trdy_q;
   assign interrupt_pin_zero_out = int_q;
   assign sample_ready_out       = ready_q;

   property p_count_bound;
      @(posedge clk_in) disable iff (!rst_n_q) qif.count <= tsf_pkg::CNT_W'(DEPTH);
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("count above depth");

   property p_pop_second;
      @(posedge clk_in) disable iff (!rst_n_q)
         (pop_w && !sample_valid_in && !flush_w) |=> qif.count == $past(qif.count) - 1'b1;
   endproperty
   a_pop_second: assert property (p_pop_second) else $error("burst did not pop one");

   property p_partial;
      @(posedge clk_in) disable iff (!rst_n_q)
         (rd_data && !byte_sel_q && qif.pop_valid && !sample_valid_in)
         |=> $stable(qif.count) && byte_sel_q;
   endproperty
   a_partial: assert property (p_partial) else $error("first byte changed count");

   property p_high_first;
      @(posedge clk_in) disable iff (!rst_n_q)
         (rd_data && !byte_sel_q && qif.pop_valid) |=> rdata_q == $past(qif.pop_data[15:8]);
   endproperty
   a_high_first: assert property (p_high_first) else $error("first byte not high");

   property p_discard;
      @(posedge clk_in) disable iff (!rst_n_q)
         (sample_valid_in && qif.full && !rollover_q && !pop_w && !reg_wr_in)
         |=> $stable(qif.wr_index) && $stable(qif.rd_index);
   endproperty
   a_discard: assert property (p_discard) else $error("full queue took sample");

   property p_lost_sat;
      @(posedge clk_in) disable iff (!rst_n_q)
         (lost_q == tsf_pkg::LOST_MAX && !pop_w && !flush_w) |=> lost_q == tsf_pkg::LOST_MAX;
   endproperty
   a_lost_sat: assert property (p_lost_sat) else $error("lost count wrapped");

   property p_flush;
      @(posedge clk_in) disable iff (!rst_n_q)
         flush_w |=> qif.count == '0 && lost_q == '0 && qif.wr_index == '0 && qif.rd_index == '0;
   endproperty
   a_flush: assert property (p_flush) else $error("flush left state");

   property p_int_pin;
      @(posedge clk_in) disable iff (!rst_n_q)
         ##1 int_q == ($past(afull_q) && $past(afull_int_en_in)
                       && $past(pin_zero_function_in) == tsf_pkg::PIN_FUNC_INTR);
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("pin zero mismatch");

   property p_status_clear;
      @(posedge clk_in) disable iff (!rst_n_q)
         (rd_status && !afull_set) |=> !afull_q;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("flag not cleared");

   property p_both_keep;
      @(posedge clk_in) disable iff (!rst_n_q)
         (pop_w && push_w && !flush_w) |=> $stable(qif.count);
   endproperty
   a_both_keep: assert property (p_both_keep) else $error("count moved on push+pop");
endmodule : tsf_sample_fifo

// ===== testbench/tsf_host_model.sv
// Purpose: host side register master for the sample queue
// Assumes: strobes change just after the falling clock edge
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module tsf_host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic [7:0]      addr_out,
   output logic            wr_out,
   output logic [7:0]      wdata_out,
   output logic            rd_out
);
   initial begin
      addr_out  = 8'hFF;
      wr_out    = 1'b0;
      wdata_out = 8'h00;
      rd_out    = 1'b0;
   end

   // one byte; a sample is two of these at the data port
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk_in);
      addr_out = addr;
      rd_out   = 1'b1;
      @(negedge clk_in);
      rd_out   = 1'b0;
      addr_out = ~addr;
      data     = rdata_in;
   endtask : read_reg

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_in);
      addr_out  = addr;
      wdata_out = data;
      wr_out    = 1'b1;
      @(negedge clk_in);
      wr_out    = 1'b0;
      addr_out  = ~addr;
      wdata_out = ~data;
   endtask : write_reg

   // samples waiting to drain; 32 once any sample was lost
   function automatic logic [7:0] avail(input logic [7:0] lost, input logic [7:0] cnt);
      return (lost == 8'h00) ? cnt : 8'h20;
   endfunction : avail
endmodule : tsf_host_model

// ===== testbench/tsf_sample_fifo_bench.sv
// Purpose: self-checking bench for the sample queue register front
// Assumes: fixed read latency of one cycle on the register port
// Notes:   all inputs change on the falling clock edge
`timescale 1ns/10ps
module tsf_sample_fifo_bench;
   logic        clk_in          = 1'b0;
   logic        resetn_in       = 1'b0;
   logic        sample_valid_in = 1'b0;
   logic [15:0] sample_in       = 16'h0000;
   logic        int_en          = 1'b1;
   logic [1:0]  pin_func        = 2'h3;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  rdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        hold;
   logic        afull;
   logic        trdy;
   logic        irq;
   logic        rdy;
   logic [15:0] s;
   logic [7:0]  lost;
   logic [7:0]  cnt;
   int          error_cnt = 0;
   int          tests_run = 0;

   always #12.5 clk_in = ~clk_in;

   tsf_sample_fifo tsf_sample_fifo_inst (
      .clk_in(clk_in), .resetn_in(resetn_in), .sample_valid_in(sample_valid_in),
      .sample_in(sample_in), .sample_ready_out(rdy), .reg_addr_in(reg_addr),
      .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
      .reg_rdata_out(rdata), .addr_hold_out(hold), .afull_int_en_in(int_en),
      .pin_zero_function_in(pin_func), .almost_full_flag_out(afull),
      .temp_ready_flag_out(trdy), .interrupt_pin_zero_out(irq));

   tsf_host_model tsf_host_model_inst (
      .clk_in(clk_in), .rdata_in(rdata), .addr_out(reg_addr), .wr_out(reg_wr),
      .wdata_out(reg_wdata), .rd_out(reg_rd));

   task automatic final_report;
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : chk8

   task automatic chk1(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %s expected %b seen %b", name, exp, got);
         error_cnt++;
      end
   endtask : chk1

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string name);
      logic [7:0] d;
      tsf_host_model_inst.read_reg(addr, d);
      chk8(name, exp, d);
   endtask : rd_chk

   task automatic push(input logic [15:0] v);
      @(negedge clk_in);
      sample_valid_in = 1'b1;
      sample_in       = v;
      @(negedge clk_in);
      sample_valid_in = 1'b0;
      sample_in       = ~v;
   endtask : push

   function automatic logic [15:0] smp(input int i);
      return {8'h40 + 8'(i), 8'hC0 - 8'(i)};
   endfunction : smp

   initial begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      final_report;
   end

   initial begin
      repeat (4) @(negedge clk_in);
      resetn_in = 1'b1;
      repeat (3) @(negedge clk_in);
      for (int a = 4; a < 8; a++) rd_chk(8'(a), 8'h00, "reset value");
      // byte order, burst pop, same-cycle push and pop
      tsf_host_model_inst.write_reg(8'h0A, 8'h08);
      push(smp(50));
      push(smp(51));
      chk1("temp ready", 1'b1, trdy);
      s = smp(50);
      rd_chk(8'h08, s[15:8], "data high");
      chk1("temp ready after data read", 1'b0, trdy);
      chk1("address hold", 1'b1, hold);
      fork
         push(smp(52));
         rd_chk(8'h08, s[7:0], "data low");
      join
      rd_chk(8'h07, 8'h02, "count after push and pop");
      chk1("address hold", 1'b0, hold);
      rd_chk(8'h05, 8'h01, "read index");
      rd_chk(8'h04, 8'h03, "write index");
      s = smp(51);
      rd_chk(8'h08, s[15:8], "data high");
      rd_chk(8'h07, 8'h02, "count after partial read");
      rd_chk(8'h08, s[15:8], "data high again");
      rd_chk(8'h08, s[7:0], "data low");
      tsf_host_model_inst.write_reg(8'h07, 8'h15);
      rd_chk(8'h07, 8'h01, "read-only count");
      rd_chk(8'h30, 8'h00, "unmapped");
      tsf_host_model_inst.write_reg(8'h0A, 8'h10);
      rd_chk(8'h0A, 8'h00, "flush self clears");
      for (int a = 4; a < 8; a++) rd_chk(8'(a), 8'h00, "after flush");
      // watermark, overflow without and with rollover
      tsf_host_model_inst.write_reg(8'h09, 8'h02);
      rd_chk(8'h09, 8'h02, "watermark");
      for (int i = 0; i < 29; i++) push(smp(i));
      chk1("almost full below mark", 1'b0, afull);
      push(smp(29));
      chk1("almost full at mark", 1'b1, afull);
      @(negedge clk_in);
      chk1("interrupt", 1'b1, irq);
      pin_func = 2'h2;
      repeat (2) @(negedge clk_in);
      chk1("interrupt other function", 1'b0, irq);
      pin_func = 2'h3;
      rd_chk(8'h00, 8'h00, "status");
      chk1("almost full cleared", 1'b0, afull);
      push(smp(30));
      chk1("almost full reasserts", 1'b1, afull);
      for (int i = 31; i < 34; i++) push(smp(i));
      rd_chk(8'h06, 8'h02, "lost count");
      rd_chk(8'h07, 8'h20, "count full");
      chk1("ready when full", 1'b0, rdy);
      rd_chk(8'h04, 8'h00, "write index wraps");
      tsf_host_model_inst.read_reg(8'h06, lost);
      tsf_host_model_inst.read_reg(8'h07, cnt);
      chk8("available", 8'h20, tsf_host_model_inst.avail(lost, cnt));
      s = smp(0);
      rd_chk(8'h08, s[15:8], "oldest kept high");
      rd_chk(8'h08, s[7:0], "oldest kept low");
      rd_chk(8'h06, 8'h00, "lost cleared by pop");
      rd_chk(8'h07, 8'h1F, "count after pop");
      tsf_host_model_inst.write_reg(8'h0A, 8'h06);
      rd_chk(8'h00, 8'h00, "status");
      push(smp(34));
      push(smp(35));
      chk1("style high stays clear", 1'b0, afull);
      rd_chk(8'h05, 8'h02, "read index after overwrite");
      rd_chk(8'h07, 8'h20, "count after overwrite");
      chk1("ready with rollover", 1'b1, rdy);
      s = smp(2);
      rd_chk(8'h08, s[15:8], "oldest after overwrite");
      final_report;
   end
endmodule : tsf_sample_fifo_bench
